// ### cadc_ctrl.v
// control logic for eight configurable analog/digital channels
// assumes an ahb-lite master, an i2c front end that pulses ack_addr_rise,
// and an analog converter whose code on adc_sample_data is settled at conversion end
//
// Local design decisions: register access over AHB-Lite and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "cadc_defs.vh"

module cadc_ctrl
#(
  parameter NCH = 8,
  parameter CW = 12,
  parameter TRACK_CYC = `CADC_TRACK_CYC,
  parameter CONV_CYC = `CADC_CONV_CYC
)
(
  // clock, reset, enable
  input wire clk,
  input wire rst_n,
  input wire ce,
  // ahb-lite slave
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // hardware load strobe, one-cycle pulse
  input wire load_dac_strobe,
  // acknowledge clock rise after the slave address, one-cycle pulse
  input wire ack_addr_rise,
  // per-pin function selects
  output reg [NCH-1:0] pin_dac_drive,
  output reg [NCH-1:0] pin_adc_connect,
  output reg [NCH-1:0] pin_gpo_drive,
  output reg [NCH-1:0] pin_gpi_sense,
  // analog controls
  output reg dac_gain2,
  output reg adc_gain2,
  output reg [NCH*CW-1:0] dac_code_out,
  // converter side
  output reg [3:0] adc_mux_sel,
  output reg adc_track,
  output reg adc_convert,
  input wire [CW-1:0] adc_sample_data
);

  // state codes
  localparam ST_IDLE = 2'd0;
  localparam ST_TRACK = 2'd1;
  localparam ST_CONV = 2'd2;

  // reset synchroniser
  reg rst_meta;
  reg rst_sync_n;

  // bus address phase capture
  reg dph_write;
  reg [7:0] dph_addr;

  // programming state
  reg [31:0] gp_ctrl;
  reg [NCH-1:0] dac_cfg;
  reg [NCH-1:0] adc_cfg;
  reg [NCH-1:0] gpo_cfg;
  reg [NCH-1:0] gpi_cfg;
  reg load_mode;
  reg [NCH:0] seq_mask;
  reg [CW-1:0] dac_in [0:NCH-1];
  reg [CW-1:0] result [0:NCH];
  reg [31:0] last_result;

  // sequencer
  reg [1:0] state;
  reg [3:0] cur_ch;
  reg [15:0] cnt;
  reg tracked;

  // helper wires
  wire addr_take = hsel & htrans[1] & hready;
  wire wr_now = dph_write;
  wire [3:0] next_after_cur;
  wire [3:0] first_ch;
  integer i;
  integer j; // sequencer's own loop index, so each index has one driver

  // lowest selected channel at or above a start point, or none
  function [3:0] next_sel;
    input [NCH:0] mask;
    input [4:0] from;
    integer k;
    begin
      next_sel = `CADC_NO_CH;
      for (k = NCH; k >= 0; k = k - 1)
        if (mask[k] && (k >= from))
          next_sel = k[3:0];
    end
  endfunction

  assign first_ch = next_sel(seq_mask, 5'd0);
  assign next_after_cur = next_sel(seq_mask, {1'b0, cur_ch} + 5'd1);
  // zero wait state slave, never an error
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // async assert, two-flop release
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // read decode for one register word
  function [31:0] rd_word;
    input [7:0] a;
    begin
      rd_word = 32'h0000_0000;
      case (a)
        `CADC_GP_CTRL: rd_word = gp_ctrl;
        `CADC_DAC_CFG: rd_word = {24'h00_0000, dac_cfg};
        `CADC_ADC_CFG: rd_word = {24'h00_0000, adc_cfg};
        `CADC_GPO_CFG: rd_word = {24'h00_0000, gpo_cfg};
        `CADC_GPI_CFG: rd_word = {24'h00_0000, gpi_cfg};
        `CADC_LOAD_MODE: rd_word = {31'h0000_0000, load_mode};
        `CADC_SEQ: rd_word = {23'h00_0000, seq_mask};
        `CADC_LAST_RESULT: rd_word = last_result;
        `CADC_STATUS: rd_word = {24'h00_0000, cur_ch, tracked, state, (state != ST_IDLE)};
        default:
        begin
          // dac input and result windows, unmapped reads zero
          if (a[7:5] == 3'b010)
            rd_word = {20'h0_0000, dac_in[a[4:2]]};
          else if ((a[7:6] == 2'b10) && (a[5:2] <= 4'd8))
            rd_word = {16'h0000, a[5:2], result[a[5:2]]};
        end
      endcase
    end
  endfunction

  // bus capture and read data, sampled at the address phase
  always @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      dph_write <= 1'b0;
      dph_addr <= 8'h00;
      hrdata <= 32'h0000_0000;
    end
    else if (ce)
    begin
      dph_write <= addr_take & hwrite;
      dph_addr <= {haddr[7:2], 2'b00};
      if (addr_take && !hwrite)
        hrdata <= rd_word({haddr[7:2], 2'b00});
    end
  end

  // configuration registers and dac path
  always @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      gp_ctrl <= `CADC_GP_CTRL_RST;
      dac_cfg <= `CADC_CFG_RST;
      adc_cfg <= `CADC_CFG_RST;
      gpo_cfg <= `CADC_CFG_RST;
      gpi_cfg <= `CADC_CFG_RST;
      load_mode <= 1'b0;
      dac_code_out <= {NCH*CW{1'b0}};
      for (i = 0; i < NCH; i = i + 1)
        dac_in[i] <= {CW{1'b0}};
    end
    else if (ce)
    begin
      if (wr_now)
      begin
        case (dph_addr)
          `CADC_GP_CTRL: gp_ctrl <= hwdata;
          `CADC_DAC_CFG: dac_cfg <= hwdata[NCH-1:0];
          `CADC_ADC_CFG: adc_cfg <= hwdata[NCH-1:0];
          `CADC_GPO_CFG: gpo_cfg <= hwdata[NCH-1:0];
          `CADC_GPI_CFG: gpi_cfg <= hwdata[NCH-1:0];
          `CADC_LOAD_MODE: load_mode <= hwdata[0];
          default:
          begin
            // code kept as plain binary, no offset or sign
            if (dph_addr[7:5] == 3'b010)
              dac_in[dph_addr[4:2]] <= hwdata[CW-1:0];
          end
        endcase
      end
      // immediate update follows the write by one cycle
      if (wr_now && (dph_addr[7:5] == 3'b010) && !load_mode)
        dac_code_out[dph_addr[4:2]*CW +: CW] <= hwdata[CW-1:0];
      // pending inputs move out together on a strobe
      if ((wr_now && (dph_addr == `CADC_LOAD_STROBE) && hwdata[0]) || load_dac_strobe)
      begin
        for (i = 0; i < NCH; i = i + 1)
          dac_code_out[i*CW +: CW] <= dac_in[i];
      end
    end
  end

  // pin functions and shared range bits
  always @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      pin_dac_drive <= {NCH{1'b0}};
      pin_adc_connect <= {NCH{1'b0}};
      pin_gpo_drive <= {NCH{1'b0}};
      pin_gpi_sense <= {NCH{1'b0}};
      dac_gain2 <= 1'b0;
      adc_gain2 <= 1'b0;
    end
    else if (ce)
    begin
      pin_dac_drive <= dac_cfg;
      // mux stays on a dac pin so its voltage can be monitored
      pin_adc_connect <= adc_cfg;
      // dac wins the pin over a digital output
      pin_gpo_drive <= gpo_cfg & ~dac_cfg;
      pin_gpi_sense <= gpi_cfg;
      dac_gain2 <= gp_ctrl[`CADC_DAC_RANGE_BIT];
      adc_gain2 <= gp_ctrl[`CADC_ADC_RANGE_BIT];
    end
  end

  // adc sequencer
  // a trigger before the track time has run is held off, not dropped
  reg pend_trig;
  always @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      state <= ST_IDLE;
      seq_mask <= `CADC_SEQ_RST;
      cur_ch <= `CADC_NO_CH;
      cnt <= 16'h0000;
      tracked <= 1'b0;
      pend_trig <= 1'b0;
      adc_mux_sel <= 4'h0;
      adc_track <= 1'b0;
      adc_convert <= 1'b0;
      last_result <= 32'h0000_0000;
      for (j = 0; j <= NCH; j = j + 1)
        result[j] <= {CW{1'b0}};
    end
    else if (ce)
    begin
      // read of last result clears valid; a new result wins
      if (addr_take && !hwrite && ({haddr[7:2], 2'b00} == `CADC_LAST_RESULT))
        last_result[`CADC_RES_VALID_BIT] <= 1'b0;
      if (wr_now && (dph_addr == `CADC_SEQ))
      begin
        // new selection restarts tracking on its first channel
        seq_mask <= hwdata[NCH:0];
        cur_ch <= next_sel(hwdata[NCH:0], 5'd0);
        adc_mux_sel <= next_sel(hwdata[NCH:0], 5'd0);
        state <= (next_sel(hwdata[NCH:0], 5'd0) == `CADC_NO_CH) ? ST_IDLE : ST_TRACK;
        adc_track <= (next_sel(hwdata[NCH:0], 5'd0) != `CADC_NO_CH);
        adc_convert <= 1'b0;
        cnt <= 16'h0000;
        tracked <= 1'b0;
        pend_trig <= 1'b0;
      end
      else
      begin
        case (state)
          ST_IDLE:
          begin
            adc_track <= 1'b0;
            adc_convert <= 1'b0;
          end
          ST_TRACK:
          begin
            if (ack_addr_rise)
              pend_trig <= 1'b1;
            if (cnt < TRACK_CYC[15:0])
              cnt <= cnt + 16'h0001;
            else
              tracked <= 1'b1;
            // hold starts on the acknowledge edge once tracked
            if (tracked && (ack_addr_rise || pend_trig))
            begin
              state <= ST_CONV;
              adc_track <= 1'b0;
              adc_convert <= 1'b1;
              cnt <= 16'h0000;
              pend_trig <= 1'b0;
            end
          end
          ST_CONV:
          begin
            cnt <= cnt + 16'h0001;
            if (cnt == CONV_CYC[15:0] - 16'h0001)
            begin
              adc_convert <= 1'b0;
              result[cur_ch] <= adc_sample_data;
              // temperature carries id 8, never a dac0 id
              last_result <= {1'b1, 15'h0000, cur_ch, adc_sample_data};
              cnt <= 16'h0000;
              tracked <= 1'b0;
              if (next_after_cur == `CADC_NO_CH)
              begin
                // sequence done; rearm on first channel for the next read
                cur_ch <= first_ch;
                adc_mux_sel <= first_ch;
                state <= ST_TRACK;
                adc_track <= 1'b1;
              end
              else
              begin
                // further channels convert without another trigger
                cur_ch <= next_after_cur;
                adc_mux_sel <= next_after_cur;
                state <= ST_TRACK;
                adc_track <= 1'b1;
                pend_trig <= 1'b1;
              end
            end
          end
          default:
          begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ### cadc_ctrl_bench.sv
// self-checking bench for the channel control block
// assumes one ahb-lite slave, so its hreadyout is hready
`timescale 1ns/100ps
`default_nettype none
module cadc_ctrl_bench;
  localparam TC = 4; // shortened track count
  localparam CC = 8; // shortened conversion count
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic strobe = 1'b0;
  logic req = 1'b0;
  logic [31:0] r;
  int failures = 0;
  int comparisons = 0;
  int n;
  int m;
  wire hrdy, hresp, ack, dg, ag, trk, cnv;
  wire [31:0] hrdata;
  wire [7:0] dacp, adcp, gpop, gpip;
  wire [95:0] code;
  wire [3:0] sel;
  wire [11:0] smp;
  always #5 clk = ~clk;
  cadc_ctrl #(.TRACK_CYC(TC), .CONV_CYC(CC)) dut
  (
    .clk(clk), .rst_n(rst_n), .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hready(hrdy), .hwdata(hwdata), .hreadyout(hrdy),
    .hresp(hresp), .hrdata(hrdata), .load_dac_strobe(strobe), .ack_addr_rise(ack),
    .pin_dac_drive(dacp), .pin_adc_connect(adcp), .pin_gpo_drive(gpop), .pin_gpi_sense(gpip),
    .dac_gain2(dg), .adc_gain2(ag), .dac_code_out(code), .adc_mux_sel(sel),
    .adc_track(trk), .adc_convert(cnv), .adc_sample_data(smp)
  );
  cadc_far far (.clk(clk), .req(req), .adc_mux_sel(sel), .adc_convert(cnv), .adc_sample_data(smp),
    .ack_addr_rise(ack));
  task automatic conclude();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      failures++;
    end
  endtask
  // bounded wait for hready sampled high
  task automatic hold();
    int k;
    k = 0;
    @(posedge clk);
    while (hrdy !== 1'b1)
    begin
      k++;
      if (k > 50)
      begin
        failures++;
        conclude();
      end
      @(posedge clk);
    end
  endtask
  // one single word transfer, entered just after a rising edge
  task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    hold();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    hold();
    r = hrdata;
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    xf(1'b0, a, 32'h0);
    chk(nm, e, r);
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd("ctrl rst", 8'h00, 32'h0);
    xf(1'b1, 8'hfc, 32'hffff_ffff);
    rd("unmapped", 8'hfc, 32'h0);
    xf(1'b1, 8'h00, 32'h10);
    repeat (2) @(posedge clk);
    // ready high, okay response, dac gain 2, adc gain 1
    chk("gains", 32'ha, {hrdy, hresp, dg, ag});
    xf(1'b1, 8'h00, 32'h20);
    repeat (2) @(posedge clk);
    chk("gains", 32'h1, {dg, ag});
    xf(1'b1, 8'h04, 32'h81);
    xf(1'b1, 8'h08, 32'h83);
    xf(1'b1, 8'h0c, 32'h0f);
    xf(1'b1, 8'h10, 32'h30);
    repeat (2) @(posedge clk);
    chk("pins", 32'h810e_8330, {dacp, gpop, adcp, gpip});
    for (int i = 0; i < 8; i++)
    begin
      n = (i == 7) ? 'hfff : 'h111 * i;
      xf(1'b1, 8'h40 + 8'(4 * i), 32'hfff0_0000 | n);
      repeat (2) @(posedge clk);
      chk("dac now", n, code[i*12+:12]);
    end
    xf(1'b1, 8'h14, 32'h1);
    xf(1'b1, 8'h48, 32'habc);
    xf(1'b1, 8'h4c, 32'h456);
    repeat (2) @(posedge clk);
    chk("held", 32'h333222, code[47:24]);
    xf(1'b1, 8'h18, 32'h1);
    repeat (2) @(posedge clk);
    chk("sw strobe", 32'h456abc, code[47:24]);
    xf(1'b1, 8'h50, 32'h7ff);
    repeat (3) @(posedge clk);
    chk("held", 32'h444, code[59:48]);
    strobe <= 1'b1;
    @(posedge clk);
    strobe <= 1'b0;
    repeat (2) @(posedge clk);
    chk("pin strobe", 32'h7ff, code[59:48]);
    xf(1'b1, 8'h1c, 32'h101);
    repeat (2) @(posedge clk);
    chk("track", 32'h10, {trk, sel});
    repeat (TC + 2) @(posedge clk);
    req <= 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      n = 0;
      m = 0;
      while (cnv !== 1'b1 && n < 100)
      begin
        @(posedge clk);
        n++;
      end
      while (cnv === 1'b1 && m < 100)
      begin
        @(posedge clk);
        m++;
      end
      chk("conv time", 32'h1, n < 100 && m > 0 && m <= CC);
    end
    req <= 1'b0;
    repeat (2) @(posedge clk);
    rd("res ch0", 8'h80, 32'h0000_003c);
    rd("res temp", 8'ha0, 32'h0000_883c);
    rd("last", 8'h20, 32'h8000_883c);
    rd("last again", 8'h20, 32'h0000_883c);
    // rearmed on channel 0: tracked, tracking state, busy
    rd("status", 8'h24, 32'h0000_000b);
    // empty selection drops back to idle with no channel
    xf(1'b1, 8'h1c, 32'h0);
    repeat (2) @(posedge clk);
    chk("idle", 32'h0, {trk, cnv});
    rd("status idle", 8'h24, 32'h0000_00f0);
    conclude();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    conclude();
  end
endmodule
`default_nettype wire

// ### cadc_ctrl_sva.sv
// assertions for the channel control block
// assumes ce held high and a single ahb-lite slave
`timescale 1ns/100ps
`default_nettype none
module cadc_ctrl_sva
#(
  parameter NCH = 8,
  parameter CW = 12,
  parameter TRACK_CYC = 50,
  parameter CONV_CYC = 200
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register bus
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  // channel side
  input wire logic load_dac_strobe,
  input wire logic ack_addr_rise,
  input wire logic [NCH-1:0] pin_dac_drive,
  input wire logic dac_gain2,
  input wire logic adc_gain2,
  input wire logic [NCH*CW-1:0] dac_code_out,
  input wire logic adc_track,
  input wire logic adc_convert
);
  logic wph; // write data phase
  logic [7:0] wa; // its address
  logic defer; // deferred load mode copy
  int trk; // track cycles before a conversion
  int cnv; // conversion cycles so far
  // either strobe source, checked over a few cycles
  wire strb = load_dac_strobe | (wph & (wa == 8'h18) & hwdata[0]);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // shadow of write phases and converter timing
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wph <= 1'b0;
      wa <= 8'h00;
      defer <= 1'b0;
      trk <= 0;
      cnv <= 0;
    end
    else
    begin
      wph <= hsel & htrans[1] & hready & hwrite;
      wa <= haddr;
      if (wph && wa == 8'h14)
        defer <= hwdata[0];
      trk <= (adc_track && !adc_convert) ? trk + 1 : 0;
      cnv <= adc_convert ? cnv + 1 : 0;
    end
  end
  sequence s_wr(logic [7:0] a);
    wph && wa == a;
  endsequence
  a_dac_gain:
  assert property (s_wr(8'h00) |-> ##2 dac_gain2 == $past(hwdata[4], 2)) else $error("dac range wrong");
  a_adc_span:
  assert property (s_wr(8'h00) |-> ##2 adc_gain2 == $past(hwdata[5], 2)) else $error("adc range wrong");
  a_pin_func:
  assert property (s_wr(8'h04) |-> ##2 pin_dac_drive == $past(hwdata[7:0], 2)) else $error("dac pins wrong");
  a_dac_now:
  assert property (s_wr(8'h40) ##0 !defer |-> ##2 dac_code_out[11:0] == $past(hwdata[11:0], 2))
    else $error("dac not updated");
  a_dac_hold:
  assert property (defer && $past(defer, 3) && !$past(strb) && !$past(strb, 2) |-> $stable(dac_code_out))
    else $error("dac moved without strobe");
  a_track_start:
  assert property (s_wr(8'h1c) ##0 hwdata[8:0] != 9'h000 |-> ##[1:3] adc_track) else $error("no tracking");
  a_track_min:
  assert property ($rose(adc_convert) |-> trk >= TRACK_CYC) else $error("track too short");
  a_conv_len:
  assert property (adc_convert |-> cnv < CONV_CYC) else $error("conversion too long");
  a_ack_start:
  assert property (ack_addr_rise && adc_track && !adc_convert && trk > TRACK_CYC |-> ##[1:3] adc_convert)
    else $error("ack did not start conversion");
endmodule
bind cadc_ctrl cadc_ctrl_sva #(.NCH(NCH), .CW(CW), .TRACK_CYC(TRACK_CYC), .CONV_CYC(CONV_CYC)) chk (.*);
`default_nettype wire

// ### cadc_defs.vh
// constants for the configurable channel control block
// assumes a 32-bit ahb-lite register bus and a 100 mhz clock
`ifndef CADC_DEFS_VH
`define CADC_DEFS_VH
// register byte offsets
`define CADC_GP_CTRL 8'h00
`define CADC_DAC_CFG 8'h04
`define CADC_ADC_CFG 8'h08
`define CADC_GPO_CFG 8'h0c
`define CADC_GPI_CFG 8'h10
`define CADC_LOAD_MODE 8'h14
`define CADC_LOAD_STROBE 8'h18
`define CADC_SEQ 8'h1c
`define CADC_LAST_RESULT 8'h20
`define CADC_STATUS 8'h24
`define CADC_DAC_BASE 8'h40
`define CADC_RES_BASE 8'h80
// field positions
`define CADC_DAC_RANGE_BIT 4
`define CADC_ADC_RANGE_BIT 5
`define CADC_SEQ_TEMP_BIT 8
`define CADC_RES_VALID_BIT 31
// reset values
`define CADC_GP_CTRL_RST 32'h0000_0000
`define CADC_CFG_RST 8'h00
`define CADC_SEQ_RST 9'h000
// channel identifiers
`define CADC_TEMP_ID 4'h8
`define CADC_NO_CH 4'hf
// timing in ns, clock period in ns
`define CADC_CLK_NS 10
`define CADC_TRACK_NS 500
`define CADC_CONV_NS 2000
// least track time rounds up, longest conversion rounds down
`define CADC_TRACK_CYC ((`CADC_TRACK_NS + `CADC_CLK_NS - 1) / `CADC_CLK_NS)
`define CADC_CONV_CYC (`CADC_CONV_NS / `CADC_CLK_NS)
`endif

// ### cadc_far.sv
// converter and bus master stand-in facing the control block
// assumes the bench raises req once per addressed transaction
`timescale 1ns/100ps
`default_nettype none
module cadc_far
(
  // clock and trigger request
  input wire logic clk,
  input wire logic req,
  // converter side
  input wire logic [3:0] adc_mux_sel,
  input wire logic adc_convert,
  output logic [11:0] adc_sample_data,
  output logic ack_addr_rise
);
  logic req_q = 1'b0; // edge detect
  // code names its channel; inverted outside conversion so stale data shows
  assign adc_sample_data = adc_convert ? {adc_mux_sel, 8'h3c} : ~{adc_mux_sel, 8'h3c};
  // one acknowledge-clock pulse per transaction
  assign ack_addr_rise = req & ~req_q;
  always @(posedge clk)
  begin
    req_q <= req;
  end
endmodule
`default_nettype wire
